// *** core/ctb_tx_order.sv ***
// Transmit buffer ordering: pending requests, arbitration, queue put index.
// Assumes the protocol engine, identifier writes and add requests all run
// on clk; add_req_mask is the data of a write to tx_add_request_reg.
// Buffers 0 to 15 are dedicated and 16 to 31 form the queue; the engine
// holds each request until it pulses tx_done for that frame.
// All inputs come from logic on clk, so none passes a synchroniser.
`timescale 1ns/100ps
`include "ctb_regs.svh"

module ctb_tx_order
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic add_req_wr,
    input wire ctb_pkg::ctb_vec_type add_req_mask,
    input wire logic id_wr,
    input wire ctb_pkg::ctb_idx_type id_wr_buf,
    input wire ctb_pkg::ctb_id_type id_wr_val,
    input wire logic tx_done,
    output ctb_pkg::ctb_vec_type pending_q,
    output logic tx_req_q,
    output ctb_pkg::ctb_idx_type tx_buf_q,
    output ctb_pkg::ctb_id_type tx_id_q,
    output ctb_pkg::ctb_idx_type put_idx_q,
    output logic queue_full_q
);

    // Lowest set bit of a vector, with a flag for an empty vector.
    // The flag is the top bit, so a caller tests one bit for empty.
    function automatic logic [`CTB_IDX_W:0] lowest_set
    (
        input ctb_pkg::ctb_vec_type vec
    );
        logic [`CTB_IDX_W:0] res;
        res = '0;
        // Scanning downwards lets the lowest set bit make the last hit.
        for (int i = `CTB_NUM_BUF - 1; i >= 0; i--)
        begin
            if (vec[i])
            begin
                res = {1'b1, ctb_pkg::ctb_idx_type'(i)};
            end
        end
        return res;
    endfunction

    // Identifier table.
    ctb_pkg::ctb_id_type id_q [`CTB_NUM_BUF];
    ctb_pkg::ctb_id_type id_d [`CTB_NUM_BUF];

    // Pending requests and the send handshake.
    ctb_pkg::ctb_vec_type pending_d;
    ctb_pkg::ctb_state_type state_q;
    ctb_pkg::ctb_state_type state_d;
    logic tx_req_d;
    ctb_pkg::ctb_idx_type tx_buf_d;
    ctb_pkg::ctb_id_type tx_id_d;

    // Queue put index and the lowest free queue slot.
    ctb_pkg::ctb_idx_type put_idx_d;
    logic queue_full_d;
    logic [`CTB_IDX_W:0] free_low;

    // Arbiter result.
    logic sel_found;
    ctb_pkg::ctb_idx_type sel_idx;

    // The arbiter only sees requests already registered, so a request that
    // lands in the same cycle as a choice waits for the next one, after that frame ends.
    ctb_select u_select
    (
        .pend(pending_q),
        .ids(id_q),
        .found(sel_found),
        .idx(sel_idx)
    );

    // Identifier table, written by software as it stores each message.
    // A rewrite of a pending buffer counts only at the next choice.
    always_comb
    begin
        for (int i = 0; i < `CTB_NUM_BUF; i++)
        begin
            id_d[i] = id_q[i];
        end
        // Only the addressed entry changes.
        if (id_wr)
        begin
            id_d[id_wr_buf] = id_wr_val;
        end
    end

    // Pending requests and the send handshake with the protocol engine.
    // Every value defaults to its register so each path assigns them all.
    always_comb
    begin
        pending_d = pending_q;
        state_d = state_q;
        tx_req_d = tx_req_q;
        tx_buf_d = tx_buf_q;
        tx_id_d = tx_id_q;
        case (state_q)
            ctb_pkg::CTB_IDLE:
            begin
                // The choice uses registered state only, so a write in the
                // same cycle cannot disturb a half-made decision.
                if (sel_found)
                begin
                    tx_req_d = 1'b1;
                    tx_buf_d = sel_idx;
                    tx_id_d = id_q[sel_idx];
                    state_d = ctb_pkg::CTB_SEND;
                end
                else
                begin
                    // Nothing pending: the request stays low.
                    tx_req_d = 1'b0;
                end
            end
            ctb_pkg::CTB_SEND:
            begin
                // A frame on the wire cannot be pre-empted; the choice is
                // revisited only after it has finished. The pending bit and
                // the request fall together on the done edge.
                if (tx_done)
                begin
                    pending_d[tx_buf_q] = 1'b0;
                    tx_req_d = 1'b0;
                    state_d = ctb_pkg::CTB_IDLE;
                end
            end
            default:
            begin
                // An unknown state drops the request and goes back to idle.
                tx_req_d = 1'b0;
                state_d = ctb_pkg::CTB_IDLE;
            end
        endcase
        // Applied last so a new request beats the clear of the same bit.
        // Bits already pending are ORed again, so a repeat does no harm.
        if (add_req_wr)
        begin
            pending_d = pending_d | add_req_mask;
        end
    end

    // Queue put index: lowest-numbered free queue buffer, never cyclic.
    // Built from the next pending vector so that it moves on the same edge
    // as the pending bits it follows.
    always_comb
    begin
        free_low = lowest_set(~pending_d & `CTB_QUEUE_MASK);
        put_idx_d = free_low[`CTB_IDX_W-1:0];
        queue_full_d = !free_low[`CTB_IDX_W];
        // A full queue keeps the last index; software must not add then.
        if (!free_low[`CTB_IDX_W])
        begin
            put_idx_d = put_idx_q;
        end
    end

    // Identifier table registers. Reset clears them so that a buffer never
    // stored still arbitrates with a known value.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `CTB_NUM_BUF; i++)
            begin
                id_q[i] <= `CTB_ID_RST;
            end
        end
        else
        begin
            for (int i = 0; i < `CTB_NUM_BUF; i++)
            begin
                id_q[i] <= id_d[i];
            end
        end
    end

    // Pending and handshake registers. Reset is synchronous and drops any
    // frame in flight without telling the engine.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pending_q <= `CTB_PEND_RST;
            state_q <= ctb_pkg::CTB_IDLE;
            tx_req_q <= 1'b0;
            tx_buf_q <= '0;
            tx_id_q <= `CTB_ID_RST;
        end
        else
        begin
            pending_q <= pending_d;
            state_q <= state_d;
            tx_req_q <= tx_req_d;
            tx_buf_q <= tx_buf_d;
            tx_id_q <= tx_id_d;
        end
    end

    // Put index registers. After reset every queue buffer is free, so the
    // index starts at the first queue buffer and the queue reads not full.
    // The register is only a copy; the free list itself is pending_q.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            put_idx_q <= ctb_pkg::ctb_idx_type'(`CTB_NUM_DED);
            queue_full_q <= 1'b0;
        end
        else
        begin
            put_idx_q <= put_idx_d;
            queue_full_q <= queue_full_d;
        end
    end

endmodule

// *** core/ctb_regs.svh ***
// Constants for the transmit buffer ordering block of a CAN FD channel.
// Assumes a single controller clock; included by the package and modules.
`ifndef CTB_REGS_SVH
`define CTB_REGS_SVH

`define CTB_NUM_BUF 32
`define CTB_IDX_W 5
`define CTB_ID_W 29
`define CTB_NUM_DED 16
`define CTB_QUEUE_MASK 32'hffff0000
`define CTB_PEND_RST 32'h00000000
`define CTB_ID_RST 29'h00000000

`endif

// *** core/ctb_pkg.sv ***
// Types shared by the transmit buffer ordering modules.
// Assumes ctb_regs.svh is on the include path.
`include "ctb_regs.svh"

package ctb_pkg;

    typedef logic [`CTB_ID_W-1:0] ctb_id_type;
    typedef logic [`CTB_IDX_W-1:0] ctb_idx_type;
    typedef logic [`CTB_NUM_BUF-1:0] ctb_vec_type;

    typedef enum logic [0:0] {
        CTB_IDLE,
        CTB_SEND
    } ctb_state_type;

endpackage

// *** core/ctb_select.sv ***
// Combinational arbiter that picks the next buffer to send.
// Assumes the pending vector and identifier table come from one clock domain.
`timescale 1ns/100ps
`include "ctb_regs.svh"

module ctb_select
(
    input wire ctb_pkg::ctb_vec_type pend,
    input wire ctb_pkg::ctb_id_type ids [`CTB_NUM_BUF],
    output logic found,
    output ctb_pkg::ctb_idx_type idx
);

    // Scan in ascending buffer order and replace only on a strictly lower
    // identifier, so equal identifiers keep the lowest buffer number.
    // A linear scan is deep logic, traded for small area at 32 buffers.
    always_comb
    begin
        ctb_pkg::ctb_id_type best;
        best = `CTB_ID_RST;
        found = 1'b0;
        idx = '0;
        for (int i = 0; i < `CTB_NUM_BUF; i++)
        begin
            if (pend[i] && (!found || ids[i] < best))
            begin
                found = 1'b1;
                idx = ctb_pkg::ctb_idx_type'(i);
                best = ids[i];
            end
        end
    end

endmodule

// *** tb/ctb_chk.sv ***
// Checker for the transmit ordering block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module ctb_chk
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic add_req_wr,
    input wire ctb_pkg::ctb_vec_type add_req_mask,
    input wire logic tx_done,
    input wire ctb_pkg::ctb_vec_type pending_q,
    input wire logic tx_req_q,
    input wire ctb_pkg::ctb_idx_type tx_buf_q,
    input wire ctb_pkg::ctb_id_type tx_id_q,
    input wire ctb_pkg::ctb_idx_type put_idx_q,
    input wire logic queue_full_q
);
    // All checks share one clock and are quiet in reset.
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_add;
        add_req_wr |=>
            (pending_q & $past(add_req_mask)) == $past(add_req_mask);
    endproperty
    a_add: assert property (p_add) else $error("add lost");
    property p_put;
        !queue_full_q |-> put_idx_q[4] && !pending_q[put_idx_q] &&
            ((~pending_q & 32'hffff0000 & ((32'h1 << put_idx_q) - 32'h1)) == 0);
    endproperty
    a_put: assert property (p_put) else $error("put index");
    property p_pick;
        $rose(tx_req_q) |-> pending_q[tx_buf_q];
    endproperty
    a_pick: assert property (p_pick) else $error("idle pick");
    property p_hold;
        tx_req_q && !tx_done |=>
            tx_req_q && $stable(tx_buf_q) && $stable(tx_id_q);
    endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_done;
        tx_req_q && tx_done && !add_req_wr |=>
            !tx_req_q && !pending_q[$past(tx_buf_q)];
    endproperty
    a_done: assert property (p_done) else $error("not cleared");
endmodule
bind ctb_tx_order ctb_chk i_chk (.clk(clk), .rst_b(rst_b),
    .add_req_wr(add_req_wr), .add_req_mask(add_req_mask), .tx_done(tx_done),
    .pending_q(pending_q), .tx_req_q(tx_req_q), .tx_buf_q(tx_buf_q),
    .tx_id_q(tx_id_q),
    .put_idx_q(put_idx_q), .queue_full_q(queue_full_q));

// *** tb/ctb_engine.sv ***
// Model of the protocol engine that sends each requested frame.
// Assumes the request stands until tx_done; a lower lat ends a frame early.
`timescale 1ns/100ps
module ctb_engine
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_req_q,
    input wire logic [7:0] lat,
    output logic tx_done = 1'b0
);
    logic [7:0] cnt_q = 8'h00;
    // Frame ends at the falling edge lat cycles after the first one that sees the request; a pulse of one cycle.
    always @(negedge clk)
    begin
        if (!rst_b || !tx_req_q || tx_done)
        begin
            tx_done <= 1'b0;
            cnt_q <= 8'h00;
        end
        else if (cnt_q >= lat)
            tx_done <= 1'b1;
        else
            cnt_q <= cnt_q + 8'h01;
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the transmit ordering block.
// Assumes the engine model answers each request lat and a half cycles after it is raised.
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, rst_b = 0, add_req_wr = 0, id_wr = 0;
    logic tx_done, tx_req_q, queue_full_q;
    ctb_pkg::ctb_vec_type add_req_mask = '0, pending_q;
    ctb_pkg::ctb_idx_type id_wr_buf = '0, tx_buf_q, put_idx_q;
    ctb_pkg::ctb_id_type id_wr_val = '0, tx_id_q;
    logic [7:0] lat = 8'h01;
    int mismatches = 0, n_tests = 0, cyc = 0;
    // Clock of 20 ns.
    always #10 clk = ~clk;
    ctb_tx_order i_dut (.clk(clk), .rst_b(rst_b), .add_req_wr(add_req_wr),
        .add_req_mask(add_req_mask), .id_wr(id_wr), .id_wr_buf(id_wr_buf),
        .id_wr_val(id_wr_val), .tx_done(tx_done), .pending_q(pending_q),
        .tx_req_q(tx_req_q), .tx_buf_q(tx_buf_q), .tx_id_q(tx_id_q),
        .put_idx_q(put_idx_q), .queue_full_q(queue_full_q));
    ctb_engine i_eng (.clk(clk), .rst_b(rst_b), .tx_req_q(tx_req_q),
        .lat(lat), .tx_done(tx_done));
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task add(input ctb_pkg::ctb_vec_type m);
        @(negedge clk);
        add_req_wr = 1;
        add_req_mask = m;
        @(negedge clk);
        add_req_wr = 0;
    endtask
    task set_id(input int b, input ctb_pkg::ctb_id_type v);
        @(negedge clk);
        id_wr = 1;
        id_wr_buf = b[4:0];
        id_wr_val = v;
        @(negedge clk);
        id_wr = 0;
    endtask
    // Waits, bounded, at falling edges where the registered outputs are
    // settled, for the next frame; checks it, then waits for its end.
    task sent(input int b, input ctb_pkg::ctb_id_type v);
        int k;
        k = 0;
        while (tx_req_q !== 1'b1 && k < 900)
        begin
            @(negedge clk);
            k++;
        end
        chk(tx_buf_q === b[4:0] && tx_id_q === v, "wrong frame sent");
        while (tx_req_q !== 1'b0 && k < 900)
        begin
            @(negedge clk);
            k++;
        end
        chk(k < 900, "frame timeout");
    endtask
    // Same identifier in one write, then mixed identifiers.
    task t_order;
        set_id(9, 29'h123);
        set_id(5, 29'h123);
        set_id(2, 29'h123);
        chk(pending_q === 32'h0, "same id still pending");
        add(32'h224);
        chk(pending_q === 32'h224, "group add");
        sent(2, 29'h123);
        sent(5, 29'h123);
        sent(9, 29'h123);
        set_id(3, 29'h50);
        set_id(1, 29'h60);
        set_id(7, 29'h50);
        add(32'h8a);
        sent(3, 29'h50);
        sent(7, 29'h50);
        sent(1, 29'h60);
        $display("order test done");
    endtask
    // One buffer reloaded frame by frame keeps a fixed same-id order,
    // which is how software gets one without a transmit FIFO here.
    task t_reuse;
        set_id(4, 29'h77);
        add(32'h10);
        sent(4, 29'h77);
        set_id(4, 29'h77);
        add(32'h10);
        sent(4, 29'h77);
        $display("reuse test done");
    endtask
    // Queue filled while the engine stalls, then drained.
    task t_queue;
        lat = 8'hff;
        for (int k = 16; k < 32; k++)
        begin
            add(32'h1 << k);
            chk(k < 31 ? put_idx_q === 5'(k + 1) : queue_full_q === 1,
                "put");
        end
        lat = 8'h01;
        sent(16, 29'h0);
        @(negedge clk);
        chk(put_idx_q === 5'h10 && queue_full_q === 0, "lowest free");
        for (int k = 17; k < 32; k++)
            sent(k, 29'h0);
        @(negedge clk);
        chk(pending_q === 32'h0, "drained");
        $display("queue test done");
    endtask
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            test_done;
        end
    end
    initial
    begin
        repeat (10) @(negedge clk);
        chk(pending_q === 0 && put_idx_q === 5'h10 && tx_req_q === 0 &&
            queue_full_q === 0 && tx_id_q === 0, "reset");
        rst_b = 1;
        t_order;
        t_queue;
        t_reuse;
        test_done;
    end
endmodule
